//--- verilog/sdr_pkg.sv
`default_nettype none
package sdr_pkg;
	// link request selectors
	localparam logic [1:0] SEL_CARD_DATA = 2'h0;
	localparam logic [1:0] SEL_ADDR      = 2'h1;
	localparam logic [1:0] SEL_STATUS    = 2'h2;
	localparam logic [1:0] SEL_PUBLISH   = 2'h3;
	// layout version codes
	localparam logic [1:0] LAYOUT_V1 = 2'h0;
	localparam logic [1:0] LAYOUT_V2 = 2'h1;
	// card-specific data field positions (lsb)
	localparam int P_LAYOUT   = 126;
	localparam int P_ACC_TIME = 112;
	localparam int P_ACC_CLKS = 104;
	localparam int P_RATE     = 96;
	localparam int P_CLASSES  = 84;
	localparam int P_RBL_LEN  = 80;
	localparam int P_RD_PART  = 79;
	localparam int P_WR_MIS   = 78;
	localparam int P_RD_MIS   = 77;
	localparam int P_DSR      = 76;
	localparam int P_CSIZE_V2 = 48;
	localparam int P_CSIZE_V1 = 62;
	localparam int P_CURR     = 50;
	localparam int P_MULT     = 47;
	localparam int P_ERASE_EN = 46;
	localparam int P_SECTOR   = 39;
	localparam int P_WP_SIZE  = 32;
	localparam int P_WP_EN    = 31;
	localparam int P_R2W      = 26;
	localparam int P_WBL_LEN  = 22;
	localparam int P_WR_PART  = 21;
	localparam int P_FF_GRP   = 15;
	localparam int P_COPY     = 14;
	localparam int P_PERM_WP  = 13;
	localparam int P_TMP_WP   = 12;
	localparam int P_FF       = 10;
	localparam int P_CRC      = 1;
	localparam int CRC_BITS   = 120;
	// fixed field values
	localparam logic [7:0]  ACC_TIME_1P5MS = 8'h26;
	localparam logic [7:0]  ACC_CLKS_ZERO  = 8'h00;
	localparam int          ACC_CLKS_SCALE = 100;
	localparam logic [7:0]  RATE_25MHZ     = 8'h32;
	localparam logic [7:0]  RATE_50MHZ     = 8'h5a;
	localparam logic [11:0] CLASSES_V2     = 12'h05b5;
	localparam logic [11:0] CLASSES_V1_ALL = 12'h0fff;
	localparam logic [6:0]  SECTOR_32BLK = 7'h1f;
	localparam logic [6:0]  WP_128SECT   = 7'h7f;
	localparam logic [2:0]  R2W_X16      = 3'h4;
	localparam logic [3:0]  BL_LEN_512   = 4'h9;
	localparam logic [6:0]  CRC7_POLY    = 7'h09;
	// host register offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STAT   = 8'h04;
	localparam logic [7:0] OFS_DATA   = 8'h08;
	localparam logic [7:0] OFS_INFO   = 8'h0c;
	localparam logic [7:0] OFS_CAP    = 8'h10;
	localparam logic [7:0] OFS_EXTRA  = 8'h14;
	localparam logic [1:0] HTRANS_NSQ = 2'h2;
endpackage
`default_nettype wire

//--- verilog/sdr_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sdr_link_if;
	logic        req_valid;
	logic [1:0]  req_sel;
	logic [1:0]  req_index;
	logic        spi_mode;
	logic        high_speed;
	logic        rsp_valid;
	logic [31:0] rsp_data;
	modport dev (
		input  req_valid, req_sel, req_index, spi_mode, high_speed,
		output rsp_valid, rsp_data
	);
	modport host (
		output req_valid, req_sel, req_index, spi_mode, high_speed,
		input  rsp_valid, rsp_data
	);
endinterface
`default_nettype wire

//--- verilog/sdr_crc7.sv
`timescale 1ns/1ps
`default_nettype none
module sdr_crc7
	import sdr_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst_n,
	input  wire logic       clear,
	input  wire logic       shift,
	input  wire logic       bit_in,
	output logic [6:0]      crc
);
	logic [6:0] crc_r;
	logic       fb;
	logic [6:0] crc_nxt;

	// serial divide by x^7 + x^3 + 1, message msb first
	assign fb      = bit_in ^ crc_r[6];
	assign crc_nxt = {crc_r[5:0], 1'b0} ^ (fb ? CRC7_POLY : 7'h00);
	assign crc     = crc_r;

	always_ff @(posedge core_clk) begin
		if (!rst_n || clear)
			crc_r <= 7'h00;
		else if (shift)
			crc_r <= crc_nxt;
	end
endmodule
`default_nettype wire

//--- verilog/sdr_card.sv
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - layout version 0 standard, 1 high capacity
// - host decodes fields by layout version
// - time-based read access is 1.5 ms
// - clock-based access reads 0, host scales 100
// - rate field 25 MHz default, 50 high-speed
// - command classes by layout version
// - partial reads allowed, partial writes not
// - no read or write block misalignment
// - single-block erase on, 32-block sectors
// - protect groups on, 128 sectors each
// - protection flags clear, copy flag set
// - last register bit always reads 1
// - 16-bit relative address from identification
// - status returned through card state register
// - SPI mode keeps register formats unchanged
// - SPI mode status uses shorter format
// - checksum is CRC7 with x^7+x^3+1
module sdr_card
	import sdr_pkg::*;
#(
	parameter bit          HIGH_CAP    = 1'b1,
	parameter logic [21:0] CSIZE_V2    = 22'h00_3b37,
	parameter logic [11:0] CSIZE_V1    = 12'h0fff,
	parameter logic [2:0]  CSIZE_MULT  = 3'h7,
	parameter logic [3:0]  BL_LEN_V1   = 4'h9,
	parameter logic [11:0] CURRENT_SET = 12'h0fff
)
(
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	sdr_link_if.dev           link,
	input  wire logic [31:0]  card_state_register,
	input  wire logic [15:0]  proposed_address,
	output logic [15:0]       relative_address,
	output logic              data_ready
);
	typedef enum logic [2:0] {
		ST_CRC  = 3'b001,
		ST_IDLE = 3'b010,
		ST_RESP = 3'b100
	} sdr_card_st_t;

	sdr_card_st_t  state_r;
	sdr_card_st_t  state_nxt;
	logic [6:0]    cnt_r;
	logic [6:0]    cnt_nxt;
	logic          hs_r;
	logic [6:0]    crc_r;
	logic [6:0]    crc_w;
	logic [15:0]   addr_r;
	logic [31:0]   rsp_data_r;
	logic          rsp_valid_r;
	logic [127:0]  info_w;
	logic [127:0]  info_out;
	logic [1:0]    layout_version_field;
	logic [7:0]    max_transfer_rate_field;
	logic [11:0]   command_class_field;
	logic [3:0]    bl_len;
	logic          crc_shift;
	logic          crc_bit;
	logic          take;
	logic          hs_change;
	logic [31:0]   info_word;
	logic [31:0]   status_word;
	logic [31:0]   answer;

	// capacity picks the layout once, at build time
	assign layout_version_field = HIGH_CAP ? LAYOUT_V2 : LAYOUT_V1;
	assign max_transfer_rate_field = hs_r ? RATE_50MHZ : RATE_25MHZ;
	assign command_class_field =
		HIGH_CAP ? CLASSES_V2 : CLASSES_V1_ALL;
	assign bl_len = HIGH_CAP ? BL_LEN_512 : BL_LEN_V1;

	// register content; only the rate field follows the link, through the speed grade in hs_r
	always_comb begin
		info_w = '0;
		info_w[P_LAYOUT +: 2] = layout_version_field;
		info_w[P_ACC_TIME +: 8] = ACC_TIME_1P5MS;
		info_w[P_ACC_CLKS +: 8] = ACC_CLKS_ZERO;
		info_w[P_RATE +: 8] = max_transfer_rate_field;
		info_w[P_CLASSES +: 12] = command_class_field;
		info_w[P_RBL_LEN +: 4] = bl_len;
		info_w[P_RD_PART] = 1'b1;
		info_w[P_WR_MIS] = 1'b0;
		info_w[P_RD_MIS] = 1'b0;
		info_w[P_DSR] = 1'b0;
		if (HIGH_CAP) begin
			info_w[P_CSIZE_V2 +: 22] = CSIZE_V2;
		end else begin
			info_w[P_CSIZE_V1 +: 12] = CSIZE_V1;
			info_w[P_CURR +: 12] = CURRENT_SET;
			info_w[P_MULT +: 3] = CSIZE_MULT;
		end
		info_w[P_ERASE_EN] = 1'b1;
		info_w[P_SECTOR +: 7] = SECTOR_32BLK;
		info_w[P_WP_SIZE +: 7] = WP_128SECT;
		info_w[P_WP_EN] = 1'b1;
		info_w[P_R2W +: 3] = R2W_X16;
		info_w[P_WBL_LEN +: 4] = bl_len;
		info_w[P_WR_PART] = 1'b0;
		info_w[P_FF_GRP] = 1'b0;
		info_w[P_COPY] = 1'b1;
		info_w[P_PERM_WP] = 1'b0;
		info_w[P_TMP_WP] = 1'b0;
		info_w[P_FF +: 2] = 2'h0;
	end

	// checksum is appended, then the fixed trailing one
	assign info_out = {info_w[127:8], crc_r, 1'b1};

	// serial checksum over the 120 leading bits, msb first
	assign crc_shift = (state_r == ST_CRC);
	assign crc_bit   = info_w[7'd127 - cnt_r];

	sdr_crc7 u_crc (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clear    (state_r != ST_CRC),
		.shift    (crc_shift),
		.bit_in   (crc_bit),
		.crc      (crc_w)
	);

	// a new speed grade changes the rate field, so redo the checksum
	assign hs_change = (link.high_speed != hs_r);
	assign take = (state_r == ST_IDLE) && link.req_valid && !hs_change;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		case (state_r)
			ST_CRC: begin
				cnt_nxt = cnt_r + 7'd1;
				if (cnt_r == 7'(CRC_BITS - 1))
					state_nxt = ST_IDLE;
			end
			ST_IDLE: begin
				cnt_nxt = 7'd0;
				if (hs_change)
					state_nxt = ST_CRC;
				else if (take)
					state_nxt = ST_RESP;
			end
			ST_RESP: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_CRC;
				cnt_nxt   = 7'd0;
			end
		endcase
	end

	// word 3 carries the top bits; same image in both bus modes
	assign info_word = info_out[{link.req_index, 5'd0} +: 32];

	// short form keeps the low half of the status word
	assign status_word = link.spi_mode ?
		{16'h0000, card_state_register[15:0]} :
		card_state_register;

	assign answer = (link.req_sel == SEL_CARD_DATA) ? info_word :
	                (link.req_sel == SEL_ADDR)      ? {addr_r, 16'h0000} :
	                (link.req_sel == SEL_STATUS)    ? status_word :
	                {proposed_address, 16'h0000};

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state_r <= ST_CRC;
			cnt_r   <= 7'd0;
			hs_r    <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
			if (state_r == ST_IDLE && hs_change)
				hs_r <= link.high_speed;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			crc_r <= 7'h00;
		end else if (state_r == ST_CRC && cnt_r == 7'(CRC_BITS - 1)) begin
			crc_r <= crc_nxt_final(crc_w, crc_bit);
		end
	end

	// last shift is folded in here so the result lands with the state
	function automatic logic [6:0] crc_nxt_final(
		input logic [6:0] c,
		input logic       b
	);
		crc_nxt_final = {c[5:0], 1'b0} ^ ((b ^ c[6]) ? CRC7_POLY : 7'h00);
	endfunction

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			addr_r      <= 16'h0000;
			rsp_valid_r <= 1'b0;
			rsp_data_r  <= 32'h0000_0000;
		end else begin
			rsp_valid_r <= take;
			if (take)
				rsp_data_r <= answer;
			if (take && link.req_sel == SEL_PUBLISH)
				addr_r <= proposed_address;
		end
	end

	assign link.rsp_valid = rsp_valid_r;
	assign link.rsp_data  = rsp_data_r;
	assign relative_address = addr_r;
	assign data_ready = (state_r != ST_CRC);
endmodule
`default_nettype wire

//--- verilog/sdr_host.sv
`timescale 1ns/1ps
`default_nettype none
module sdr_host
	import sdr_pkg::*;
(
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         hsel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output logic              hreadyout,
	output logic [31:0]       hrdata,
	output logic              hresp,
	sdr_link_if.host          link,
	output logic              link_hs_en
);
	logic [31:0] info_r [4];
	logic [31:0] data_r;
	logic [31:0] hrdata_r;
	logic        busy_r;
	logic        done_r;
	logic [1:0]  sel_r;
	logic [1:0]  idx_r;
	logic        spi_r;
	logic        hs_req_r;
	logic        wr_ph_r;
	logic [7:0]  wr_ofs_r;
	logic [6:0]  chk_cnt_r;
	logic        chk_busy_r;
	logic        crc_ok_r;
	logic [6:0]  crc_w;
	logic        addr_ok;
	logic [7:0]  ofs;
	logic        ctrl_wr;
	logic [127:0] info_flat;
	logic        info_in;
	logic [1:0]  layout_version;
	logic [7:0]  rate_code;
	logic [21:0] capacity;
	logic [15:0] extra_clocks;
	logic        hs_allowed;
	logic        chk_last;
	logic [31:0] rd_mux;

	assign addr_ok = hsel && htrans[1] && hready;
	assign ofs     = haddr[7:0];
	assign ctrl_wr = wr_ph_r && (wr_ofs_r == OFS_CTRL) && !busy_r;

	assign info_flat = {info_r[3], info_r[2], info_r[1], info_r[0]};
	assign layout_version = info_flat[P_LAYOUT +: 2];
	assign rate_code = info_flat[P_RATE +: 8];
	// size field sits at a different place per layout
	assign capacity = (layout_version == LAYOUT_V2) ?
		info_flat[P_CSIZE_V2 +: 22] :
		{10'h000, info_flat[P_CSIZE_V1 +: 12]};
	assign extra_clocks =
		16'(info_flat[P_ACC_CLKS +: 8] * ACC_CLKS_SCALE);
	// never clock faster than the card advertises
	assign hs_allowed = (rate_code == RATE_50MHZ);
	assign link_hs_en = hs_req_r && hs_allowed;

	// register read mux; the info register only reports the block flags, nothing enforces them
	assign rd_mux =
		(ofs == OFS_CTRL) ? {25'h0, hs_req_r, spi_r, idx_r, sel_r, 1'b0} :
		(ofs == OFS_STAT) ? {29'h0, crc_ok_r, done_r, busy_r} :
		(ofs == OFS_DATA) ? data_r :
		(ofs == OFS_INFO) ? {24'h0, info_flat[P_WR_PART],
			info_flat[P_RD_MIS], info_flat[P_WR_MIS],
			info_flat[P_RD_PART], hs_allowed, 1'b0, layout_version} :
		(ofs == OFS_CAP)  ? {10'h000, capacity} :
		(ofs == OFS_EXTRA) ? {16'h0000, extra_clocks} :
		32'h0000_0000;

	assign chk_last = (chk_cnt_r == 7'(CRC_BITS - 1));
	assign info_in  = busy_r && link.rsp_valid && sel_r == SEL_CARD_DATA;

	sdr_crc7 u_chk (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.clear    (!chk_busy_r),
		.shift    (chk_busy_r),
		.bit_in   (info_flat[7'd127 - chk_cnt_r]),
		.crc      (crc_w)
	);

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wr_ph_r  <= 1'b0;
			wr_ofs_r <= 8'h00;
			hrdata_r <= 32'h0000_0000;
		end else begin
			wr_ph_r <= addr_ok && hwrite;
			if (addr_ok)
				wr_ofs_r <= ofs;
			if (addr_ok && !hwrite)
				hrdata_r <= rd_mux;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			busy_r   <= 1'b0;
			done_r   <= 1'b0;
			sel_r    <= SEL_CARD_DATA;
			idx_r    <= 2'h0;
			spi_r    <= 1'b0;
			hs_req_r <= 1'b0;
			data_r   <= 32'h0000_0000;
		end else begin
			if (ctrl_wr) begin
				sel_r    <= hwdata[2:1];
				idx_r    <= hwdata[4:3];
				spi_r    <= hwdata[5];
				hs_req_r <= hwdata[6];
				busy_r   <= hwdata[0];
				done_r   <= hwdata[0] ? 1'b0 : done_r;
			end else if (busy_r && link.rsp_valid) begin
				busy_r <= 1'b0;
				done_r <= 1'b1;
				data_r <= link.rsp_data;
			end
		end
	end

	// keep a copy of each register word, check once word 0 arrives
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++)
				info_r[i] <= 32'h0000_0000;
			chk_busy_r <= 1'b0;
			chk_cnt_r  <= 7'd0;
			crc_ok_r   <= 1'b0;
		end else begin
			if (info_in)
				info_r[idx_r] <= link.rsp_data;
			if (info_in && idx_r == 2'h0) begin
				chk_busy_r <= 1'b1;
				chk_cnt_r  <= 7'd0;
				crc_ok_r   <= 1'b0;
			end else if (chk_busy_r) begin
				chk_cnt_r <= chk_cnt_r + 7'd1;
				if (chk_last) begin
					chk_busy_r <= 1'b0;
					crc_ok_r   <= (crc_fold(crc_w, info_flat[8]) ==
						info_flat[P_CRC +: 7]) && info_flat[0];
				end
			end
		end
	end

	function automatic logic [6:0] crc_fold(
		input logic [6:0] c,
		input logic       b
	);
		crc_fold = {c[5:0], 1'b0} ^ ((b ^ c[6]) ? CRC7_POLY : 7'h00);
	endfunction

	assign link.req_valid  = busy_r;
	assign link.req_sel    = sel_r;
	assign link.req_index  = idx_r;
	assign link.spi_mode   = spi_r;
	// ask the card to switch first; the fast clock is granted only
	// once the card's rate field advertises it
	assign link.high_speed = hs_req_r;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_r;
endmodule
`default_nettype wire

//--- sim/sdr_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sdr_sva
	import sdr_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        rst_n,
	input wire logic        req_valid,
	input wire logic [1:0]  req_sel,
	input wire logic [1:0]  req_index,
	input wire logic        spi_mode,
	input wire logic        high_speed,
	input wire logic        rsp_valid,
	input wire logic [31:0] rsp_data,
	input wire logic [31:0] card_state_register
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// answers to card data words, by word index
	wire cd = rsp_valid && req_sel == SEL_CARD_DATA;
	wire w0 = cd && req_index == 2'h0;
	wire w1 = cd && req_index == 2'h1;
	wire w2 = cd && req_index == 2'h2;
	wire w3 = cd && req_index == 2'h3;
	wire [31:0] short_st = {16'h0000, card_state_register[15:0]};
	property p_pulse; rsp_valid |=> !rsp_valid; endproperty
	a_pulse: assert property (p_pulse)
		else $error("answer pulse longer than one cycle");
	property p_ans; $rose(req_valid) |-> ##[1:200] rsp_valid; endproperty
	a_ans: assert property (p_ans)
		else $error("request not answered in time");
	property p_hold;
		req_valid && !rsp_valid |=> req_valid && $stable(req_sel)
			&& $stable(req_index);
	endproperty
	a_hold: assert property (p_hold)
		else $error("request dropped or changed before answer");
	property p_layout; w3 |-> rsp_data[31:30] == LAYOUT_V2; endproperty
	a_layout: assert property (p_layout)
		else $error("wrong layout version");
	property p_access;
		w3 |-> rsp_data[23:16] == ACC_TIME_1P5MS
			&& rsp_data[15:8] == ACC_CLKS_ZERO;
	endproperty
	a_access: assert property (p_access)
		else $error("wrong read access fields");
	property p_rate;
		w3 |-> rsp_data[7:0] == (high_speed ? RATE_50MHZ : RATE_25MHZ);
	endproperty
	a_rate: assert property (p_rate)
		else $error("wrong transfer rate code");
	property p_ccc;
		w2 |-> rsp_data[31:20] == CLASSES_V2 && rsp_data[15:13] == 3'h4;
	endproperty
	a_ccc: assert property (p_ccc)
		else $error("wrong class or block flags");
	property p_erase;
		w1 |-> rsp_data[14:0] == {1'b1, SECTOR_32BLK, WP_128SECT};
	endproperty
	a_erase: assert property (p_erase)
		else $error("wrong erase or group fields");
	property p_flags;
		w0 |-> rsp_data[31] && !rsp_data[21] && rsp_data[14:12] == 3'h4
			&& rsp_data[0];
	endproperty
	a_flags: assert property (p_flags)
		else $error("wrong flags in low word");
	property p_stat;
		rsp_valid && req_sel == SEL_STATUS |->
			rsp_data == (spi_mode ? short_st : card_state_register);
	endproperty
	a_stat: assert property (p_stat)
		else $error("wrong status form");
endmodule
`default_nettype wire

//--- sim/sdr_card_register_set_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sdr_card_register_set_tb_top;
	import sdr_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst_n    = 1'b0;
	logic        hsel     = 1'b0;
	logic        hwrite   = 1'b0;
	logic        ph       = 1'b0;
	logic [1:0]  htrans   = 2'h0;
	logic [2:0]  hsize    = 3'h2;
	logic [31:0] haddr    = 32'h0000_0000;
	logic [31:0] hwdata   = 32'h0000_0000;
	logic [31:0] st_in    = 32'h0000_0000;
	logic [15:0] pa       = 16'h0000;
	wire         hrdy;
	wire         hresp;
	wire         hs_en;
	wire         data_ready;
	wire  [31:0] hrdata;
	wire  [15:0] ra;
	int          n_fail;
	int          comparisons;
	logic [31:0] q_e[$];
	logic [31:0] q_m[$];
	logic [31:0] w[4];
	logic [31:0] ex[4];
	logic [31:0] mk[4];
	logic [31:0] v;
	logic [6:0]  c;
	always #50 core_clk = ~core_clk;
	sdr_link_if sdr_link_if_i();
	sdr_card sdr_card_i(.core_clk, .rst_n, .link(sdr_link_if_i.dev),
		.card_state_register(st_in), .proposed_address(pa),
		.relative_address(ra), .data_ready);
	sdr_host sdr_host_i(.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hrdy), .hreadyout(hrdy), .hrdata, .hresp,
		.link(sdr_link_if_i.host), .link_hs_en(hs_en));
	sdr_sva sdr_sva_i(.core_clk, .rst_n,
		.req_valid(sdr_link_if_i.req_valid), .req_sel(sdr_link_if_i.req_sel),
		.req_index(sdr_link_if_i.req_index), .spi_mode(sdr_link_if_i.spi_mode),
		.high_speed(sdr_link_if_i.high_speed),
		.rsp_valid(sdr_link_if_i.rsp_valid), .rsp_data(sdr_link_if_i.rsp_data),
		.card_state_register(st_in));
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task stop_test;
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// read data is compared at the data-phase edge against the oldest note
	always @(posedge core_clk) begin
		if (ph && hrdy === 1'b1) begin
			check(hrdata & q_m[0], q_e[0] & q_m[0]);
			void'(q_e.pop_front());
			void'(q_m.pop_front());
		end
	end
	task automatic adr(input logic [7:0] a, input logic w_en);
		@(posedge core_clk);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= HTRANS_NSQ;
		hwrite <= w_en;
		do @(posedge core_clk); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		adr(a, 1'b1);
		hwdata <= d;
		do @(posedge core_clk); while (hrdy !== 1'b1);
	endtask
	// a zero mask reads without noting an expectation
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m, output logic [31:0] d);
		adr(a, 1'b0);
		if (m != 0) begin
			q_e.push_back(e);
			q_m.push_back(m);
		end
		ph <= (m != 0);
		do @(posedge core_clk); while (hrdy !== 1'b1);
		d = hrdata;
		ph <= 1'b0;
	endtask
	task automatic poll(input logic [31:0] m);
		logic [31:0] s;
		s = 32'h0000_0000;
		for (int k = 0; k < 300 && (s & m) !== m; k++)
			rd(OFS_STAT, 32'h0, 32'h0, s);
		check(s & m, m);
	endtask
	task automatic op(input logic [1:0] s, input logic [1:0] i,
		input logic sp, input logic hs, input logic [31:0] e,
		input logic [31:0] m, output logic [31:0] d);
		wr(OFS_CTRL, {25'h000_0000, hs, sp, i, s, 1'b1});
		poll(32'h0000_0002);
		rd(OFS_DATA, e, m, d);
	endtask
	initial begin
		repeat (30000) @(posedge core_clk);
		n_fail++;
		stop_test;
	end
	initial begin
		ex = '{32'h8000_4001, 32'h0000_4fff, 32'h5b50_8000, 32'h0};
		mk = '{32'h8020_7001, 32'h0000_7fff, 32'hfff0_e000, 32'hc0ff_ffff};
		void'($urandom(68426));
		repeat (20) @(posedge core_clk);
		rst_n <= 1'b1;
		st_in <= $urandom;
		pa <= 16'($urandom);
		repeat (125) @(posedge core_clk);
		check({31'h0, data_ready}, 32'h1);
		for (int h = 0; h < 2; h++) begin
			ex[3] = {2'h1, 6'h00, ACC_TIME_1P5MS, ACC_CLKS_ZERO,
				h ? RATE_50MHZ : RATE_25MHZ};
			for (int i = 3; i >= 0; i--)
				op(SEL_CARD_DATA, i[1:0], 1'b0, h[0], ex[i], mk[i],
					w[i]);
			c = 7'h00;
			for (int b = 127; b >= 8; b--)
				c = {c[5:0], 1'b0} ^ ((c[6] ^ w[b/32][b%32]) ? CRC7_POLY : 7'h0);
			check({25'h0, w[0][7:1]}, {25'h0, c});
			poll(32'h0000_0004);
			check({31'h0, hs_en}, {31'h0, h[0]});
			$display("test card data hs=%0d done", h);
		end
		for (int s = 0; s < 2; s++)
			op(SEL_STATUS, 2'h0, s[0], 1'b0,
				s ? {16'h0000, st_in[15:0]} : st_in,
				32'hffff_ffff, v);
		op(SEL_CARD_DATA, 2'h2, 1'b1, 1'b0, ex[2], mk[2], v);
		$display("test status and spi done");
		op(SEL_PUBLISH, 2'h0, 1'b0, 1'b0, {pa, 16'h0000}, 32'hffff_0000, v);
		check({16'h0000, ra}, {16'h0000, pa});
		op(SEL_ADDR, 2'h0, 1'b0, 1'b0, {pa, 16'h0000},
			32'hffff_ffff, v);
		$display("test address done");
		rd(OFS_INFO, 32'h0000_0011, 32'h0000_00f3, v);
		rd(OFS_CAP, 32'h0000_3b37, 32'hffff_ffff, v);
		rd(OFS_EXTRA, 32'h0, 32'hffff_ffff, v);
		wr(8'h40, $urandom);
		rd(8'h40, 32'h0, 32'hffff_ffff, v);
		check({31'h0, hresp}, 32'h0);
		$display("test host registers done");
		stop_test;
	end
endmodule
`default_nettype wire
